// >>> common/acs_defines.svh
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

// clock period and rounding of times to cycles
`define ACS_CLK_NS            4
`define ACS_CEIL(ns)          (((ns) + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`define ACS_FLOOR(ns)         ((ns) / `ACS_CLK_NS)

// times in their own units
`define ACS_T_RESET_NS        50
`define ACS_T_RST_TO_CONV_NS  25
`define ACS_T_CONV_PULSE_NS   25
`define ACS_T_OS_HOLD_NS      20
`define ACS_T_BUSY_RISE_NS    40
`define ACS_T_LINK_HIGH_NS    22
`define ACS_T_RD_LOW_NS       32
`define ACS_T_RD_HIGH_NS      15
`define ACS_T_CYCLE_PAR_US    5
`define ACS_T_CYCLE_SER_NS    10500
`define ACS_T_WAKE_STANDBY_CONTROL_US    100
`define ACS_T_WAKE_INT_MS     30
`define ACS_T_WAKE_EXT_MS     13
`define ACS_T_SKEW_MAX_US     500

// derived cycle counts
`define ACS_RESET_CYC     `ACS_CEIL(`ACS_T_RESET_NS)
`define ACS_RST_GAP_CYC   `ACS_CEIL(`ACS_T_RST_TO_CONV_NS)
`define ACS_PULSE_CYC     `ACS_CEIL(`ACS_T_CONV_PULSE_NS)
`define ACS_OS_HOLD_CYC   `ACS_CEIL(`ACS_T_OS_HOLD_NS)
`define ACS_BUSY_RISE_CYC `ACS_FLOOR(`ACS_T_BUSY_RISE_NS)
`define ACS_LINK_HIGH_CYC `ACS_CEIL(`ACS_T_LINK_HIGH_NS)
`define ACS_RD_LOW_CYC    `ACS_CEIL(`ACS_T_RD_LOW_NS)
`define ACS_RD_HIGH_CYC   `ACS_CEIL(`ACS_T_RD_HIGH_NS)
`define ACS_CYCLE_PAR_CYC `ACS_CEIL(`ACS_T_CYCLE_PAR_US * 1000)
`define ACS_CYCLE_SER_CYC `ACS_CEIL(`ACS_T_CYCLE_SER_NS)
`define ACS_WAKE_STANDBY_CONTROL_CYC `ACS_CEIL(`ACS_T_WAKE_STANDBY_CONTROL_US * 1000)
`define ACS_WAKE_INT_CYC  `ACS_CEIL(`ACS_T_WAKE_INT_MS * 1000000)
`define ACS_WAKE_EXT_CYC  `ACS_CEIL(`ACS_T_WAKE_EXT_MS * 1000000)
`define ACS_SKEW_MAX_CYC  `ACS_FLOOR(`ACS_T_SKEW_MAX_US * 1000)

// widths and reset values
`define ACS_WORD_W        16
`define ACS_OS_W          3
`define ACS_TIMER_W       24
`define ACS_WORDS         16
`define ACS_OS_RST        3'h0

`endif

// >>> common/acs_pkg.sv
`default_nettype none
package acs_pkg;
  `include "acs_defines.svh"

  typedef enum logic [1:0] {
    ACS_PWR_NORMAL,
    ACS_PWR_STANDBY,
    ACS_PWR_SHUTDOWN
  } acs_power_type;

  // pins driven toward the converter
  typedef struct packed {
    logic                 conversion_start_a;
    logic                 conversion_start_b;
    logic                 standby_control;
    logic                 range_hi;
    logic                 reset;
    logic                 cs_n;
    logic                 rd_n;
    logic [`ACS_OS_W-1:0] oversample_select;
  } acs_pins_type;

  // user configuration; read_during, cs_rd_linked and serial_slow sampled when a cycle starts, the other fields read live
  typedef struct packed {
    logic                 read_during;
    logic                 cs_rd_linked;
    logic                 serial_slow;
    logic                 ext_ref;
    logic                 range_hi;
    acs_power_type        power;
    logic [`ACS_OS_W-1:0] os_ratio;
  } acs_cfg_type;

  typedef enum logic [3:0] {
    ST_RST_PULSE,
    ST_RST_GAP,
    ST_IDLE,
    ST_SLEEP,
    ST_WAKE,
    ST_CONV_A,
    ST_CONV_HI,
    ST_BUSY_RISE,
    ST_BUSY_WAIT,
    ST_READ_LO,
    ST_READ_HI
  } acs_state_type;
endpackage : acs_pkg
`default_nettype wire

// >>> hdl/acs_timer.sv
`timescale 1ns/1ps
`default_nettype none
// down counter: done while the count sits at zero
module acs_timer #(
  parameter int           W       = 24,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         ce_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] value_i,
  output logic              done_o
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // load wins over the count so a state entry restarts it
  always_comb begin
    cnt_nxt = cnt_r;
    if (load_i) begin
      cnt_nxt = value_i;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - W'(1);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cnt_r <= RST_VAL;
    end else if (ce_i) begin
      cnt_r <= cnt_nxt;
    end
  end

  assign done_o = (cnt_r == '0);
endmodule : acs_timer
`default_nettype wire

// >>> hdl/acs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.svh"
module acs_sequencer #(
  parameter int TW            = `ACS_TIMER_W,
  parameter int WORDS         = `ACS_WORDS,
  parameter int WAKE_STANDBY_CONTROL_CYC = `ACS_WAKE_STANDBY_CONTROL_CYC,
  parameter int WAKE_INT_CYC  = `ACS_WAKE_INT_CYC,
  parameter int WAKE_EXT_CYC  = `ACS_WAKE_EXT_CYC,
  parameter int SKEW_MAX_CYC  = `ACS_SKEW_MAX_CYC
) (
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    ce_i,
  input  wire logic                    start_i,
  input  wire acs_pkg::acs_cfg_type    cfg_i,
  input  wire logic [TW-1:0]           stagger_i,
  input  wire logic                    busy_i,
  input  wire logic [`ACS_WORD_W-1:0]  db_i,
  output acs_pkg::acs_pins_type        pins_o,
  output logic [`ACS_WORD_W-1:0]       data_o,
  output logic                         data_valid_o,
  output logic                         data_last_o,
  output logic                         ready_o,
  output logic                         busy_miss_o
);
  import acs_pkg::*;

  localparam int CW = $clog2(WORDS + 1);
  localparam logic [TW-1:0] RESET_LD   = TW'(`ACS_RESET_CYC - 1);
  localparam logic [TW-1:0] GAP_LD     = TW'(`ACS_RST_GAP_CYC - 1);
  localparam logic [TW-1:0] PULSE_LD   = TW'(`ACS_PULSE_CYC - 1);
  localparam logic [TW-1:0] HOLD_LD    = TW'(`ACS_OS_HOLD_CYC - 1);
  localparam logic [TW-1:0] RISE_LD    = TW'(`ACS_BUSY_RISE_CYC - 1);
  localparam logic [TW-1:0] LINK_LD    = TW'(`ACS_LINK_HIGH_CYC - 1);
  localparam logic [TW-1:0] RDLO_LD    = TW'(`ACS_RD_LOW_CYC - 1);
  localparam logic [TW-1:0] RDHI_LD    = TW'(`ACS_RD_HIGH_CYC - 1);
  localparam logic [TW-1:0] CYC_PAR_LD = TW'(`ACS_CYCLE_PAR_CYC - 1);
  localparam logic [TW-1:0] CYC_SER_LD = TW'(`ACS_CYCLE_SER_CYC - 1);
  localparam logic [TW-1:0] STANDBY_CONTROL_LD    = TW'(WAKE_STANDBY_CONTROL_CYC - 1);
  localparam logic [TW-1:0] INT_LD     = TW'(WAKE_INT_CYC - 1);
  localparam logic [TW-1:0] EXT_LD     = TW'(WAKE_EXT_CYC - 1);
  localparam logic [TW-1:0] SKEW_MAX   = TW'(SKEW_MAX_CYC);
  localparam logic [CW-1:0] LAST_WORD  = CW'(WORDS - 1);

  acs_state_type          state_r;
  acs_state_type          state_nxt;
  acs_pins_type           pins_r;
  acs_pins_type           pins_nxt;
  acs_cfg_type            cfg_r;
  acs_cfg_type            cfg_nxt;
  logic [CW-1:0]          word_r;
  logic [CW-1:0]          word_nxt;
  logic                   have_prev_r;
  logic                   have_prev_nxt;
  logic                   shutdown_r;
  logic                   shutdown_nxt;
  logic [`ACS_WORD_W-1:0] data_r;
  logic [`ACS_WORD_W-1:0] data_nxt;
  logic                   valid_r;
  logic                   valid_nxt;
  logic                   last_r;
  logic                   last_nxt;
  logic                   ready_r;
  logic                   ready_nxt;
  logic                   miss_r;
  logic                   miss_nxt;

  logic                   main_load;
  logic [TW-1:0]          main_val;
  logic                   main_done;
  logic                   cyc_load;
  logic [TW-1:0]          cyc_val;
  logic                   cyc_done;
  logic                   hold_load;
  logic                   hold_done;
  logic [TW-1:0]          skew;

  // one timer per concern: state delays, cycle spacing, select hold
  acs_timer #(
    .W       (TW),
    .RST_VAL (RESET_LD)
  ) u_main_timer (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .load_i    (main_load),
    .value_i   (main_val),
    .done_o    (main_done)
  );

  acs_timer #(
    .W       (TW),
    .RST_VAL ('0)
  ) u_cycle_timer (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .load_i    (cyc_load),
    .value_i   (cyc_val),
    .done_o    (cyc_done)
  );

  acs_timer #(
    .W       (TW),
    .RST_VAL ('0)
  ) u_hold_timer (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .load_i    (hold_load),
    .value_i   (HOLD_LD),
    .done_o    (hold_done)
  );

  // clamp the start skew so the second edge is never too late
  assign skew = (stagger_i > SKEW_MAX) ? SKEW_MAX : stagger_i;

  // sequencer next state and pin values
  always_comb begin
    state_nxt     = state_r;
    pins_nxt      = pins_r;
    cfg_nxt       = cfg_r;
    word_nxt      = word_r;
    have_prev_nxt = have_prev_r;
    shutdown_nxt  = shutdown_r;
    data_nxt      = data_r;
    valid_nxt     = 1'b0;
    last_nxt      = 1'b0;
    miss_nxt      = 1'b0;
    main_load     = 1'b0;
    main_val      = '0;
    cyc_load      = 1'b0;
    cyc_val       = cfg_r.serial_slow ? CYC_SER_LD : CYC_PAR_LD;
    hold_load     = 1'b0;
    unique case (state_r)
      ST_RST_PULSE: begin
        if (main_done) begin
          pins_nxt.reset = 1'b0;
          main_load      = 1'b1;
          main_val       = GAP_LD;
          state_nxt      = ST_RST_GAP;
        end
      end
      ST_RST_GAP: begin
        if (main_done) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        // select changes only with busy low and hold elapsed
        if (!busy_i && hold_done) begin
          pins_nxt.oversample_select = cfg_i.os_ratio;
          pins_nxt.range_hi          = cfg_i.range_hi;
        end
        if (cfg_i.power != ACS_PWR_NORMAL) begin
          pins_nxt.standby_control = 1'b0;
          pins_nxt.range_hi = (cfg_i.power == ACS_PWR_STANDBY);
          shutdown_nxt      = (cfg_i.power == ACS_PWR_SHUTDOWN);
          have_prev_nxt     = 1'b0;
          state_nxt         = ST_SLEEP;
        end else if (start_i && ready_r) begin
          cfg_nxt                     = cfg_i;
          pins_nxt.conversion_start_a = 1'b1;
          cyc_load  = 1'b1;
          cyc_val   = cfg_i.serial_slow ? CYC_SER_LD : CYC_PAR_LD;
          main_load = 1'b1;
          if (skew == '0) begin
            pins_nxt.conversion_start_b = 1'b1;
            main_val  = PULSE_LD;
            state_nxt = ST_CONV_HI;
          end else begin
            main_val  = skew - TW'(1);
            state_nxt = ST_CONV_A;
          end
        end
      end
      ST_SLEEP: begin
        if (cfg_i.power == ACS_PWR_NORMAL) begin
          pins_nxt.standby_control = 1'b1;
          pins_nxt.range_hi        = cfg_i.range_hi;
          main_load                = 1'b1;
          if (shutdown_r) begin
            main_val = cfg_i.ext_ref ? EXT_LD : INT_LD;
          end else begin
            main_val = STANDBY_CONTROL_LD;
          end
          state_nxt = ST_WAKE;
        end else begin
          pins_nxt.range_hi = (cfg_i.power == ACS_PWR_STANDBY);
          shutdown_nxt      = shutdown_r |
                              (cfg_i.power == ACS_PWR_SHUTDOWN);
        end
      end
      ST_WAKE: begin
        if (main_done) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_CONV_A: begin
        if (main_done) begin
          pins_nxt.conversion_start_b = 1'b1;
          main_load = 1'b1;
          main_val  = PULSE_LD;
          state_nxt = ST_CONV_HI;
        end
      end
      ST_CONV_HI: begin
        // both starts held high for the minimum pulse
        if (main_done) begin
          pins_nxt.conversion_start_a = 1'b0;
          pins_nxt.conversion_start_b = 1'b0;
          main_load = 1'b1;
          main_val  = RISE_LD;
          state_nxt = ST_BUSY_RISE;
        end
      end
      ST_BUSY_RISE: begin
        // converter owes busy within its start-to-busy delay
        if (busy_i || main_done) begin
          miss_nxt = !busy_i;
          if (busy_i && cfg_r.read_during && have_prev_r) begin
            pins_nxt.cs_n = 1'b0;
            pins_nxt.rd_n = 1'b0;
            word_nxt      = '0;
            main_load     = 1'b1;
            main_val      = RDLO_LD;
            state_nxt     = ST_READ_LO;
          end else begin
            state_nxt = ST_BUSY_WAIT;
          end
        end
      end
      ST_BUSY_WAIT: begin
        // conversion length varies with ratio, so watch busy
        if (!busy_i) begin
          hold_load     = 1'b1;
          have_prev_nxt = 1'b1;
          if (!cfg_r.read_during) begin
            pins_nxt.cs_n = 1'b0;
            pins_nxt.rd_n = 1'b0;
            word_nxt      = '0;
            main_load     = 1'b1;
            main_val      = RDLO_LD;
            state_nxt     = ST_READ_LO;
          end else begin
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_READ_LO: begin
        if (cfg_r.read_during && !busy_i) begin
          // busy fell mid-read: drop select on the next edge
          pins_nxt.cs_n = 1'b1;
          pins_nxt.rd_n = 1'b1;
          hold_load     = 1'b1;
          have_prev_nxt = 1'b1;
          state_nxt     = ST_IDLE;
        end else if (main_done) begin
          data_nxt      = db_i;
          valid_nxt     = 1'b1;
          last_nxt      = (word_r == LAST_WORD);
          pins_nxt.rd_n = 1'b1;
          main_load     = 1'b1;
          if (word_r == LAST_WORD) begin
            pins_nxt.cs_n = 1'b1;
            state_nxt = cfg_r.read_during ? ST_BUSY_WAIT : ST_IDLE;
          end else begin
            word_nxt = word_r + CW'(1);
            if (cfg_r.cs_rd_linked) begin
              pins_nxt.cs_n = 1'b1;
              main_val      = LINK_LD;
            end else begin
              main_val = RDHI_LD;
            end
            state_nxt = ST_READ_HI;
          end
        end
      end
      ST_READ_HI: begin
        if (cfg_r.read_during && !busy_i) begin
          pins_nxt.cs_n = 1'b1;
          hold_load     = 1'b1;
          have_prev_nxt = 1'b1;
          state_nxt     = ST_IDLE;
        end else if (main_done) begin
          pins_nxt.cs_n = 1'b0;
          pins_nxt.rd_n = 1'b0;
          main_load     = 1'b1;
          main_val      = RDLO_LD;
          state_nxt     = ST_READ_LO;
        end
      end
    endcase
  end

  // ready looks one cycle ahead so the flag matches acceptance
  always_comb begin
    ready_nxt = (state_nxt == ST_IDLE) && !busy_i &&
                (cfg_i.power == ACS_PWR_NORMAL) &&
                (cyc_done || (cyc_val == '0)) && !cyc_load;
  end

  // registers; reset drives the converter reset pin high
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_r     <= ST_RST_PULSE;
      pins_r      <= '{conversion_start_a: 1'b0,
                       conversion_start_b: 1'b0,
                       standby_control:    1'b1,
                       range_hi:           1'b0,
                       reset:              1'b1,
                       cs_n:               1'b1,
                       rd_n:               1'b1,
                       oversample_select:  `ACS_OS_RST};
      cfg_r       <= '0;
      word_r      <= '0;
      have_prev_r <= 1'b0;
      shutdown_r  <= 1'b0;
      data_r      <= '0;
      valid_r     <= 1'b0;
      last_r      <= 1'b0;
      ready_r     <= 1'b0;
      miss_r      <= 1'b0;
    end else if (ce_i) begin
      state_r     <= state_nxt;
      pins_r      <= pins_nxt;
      cfg_r       <= cfg_nxt;
      word_r      <= word_nxt;
      have_prev_r <= have_prev_nxt;
      shutdown_r  <= shutdown_nxt;
      data_r      <= data_nxt;
      valid_r     <= valid_nxt;
      last_r      <= last_nxt;
      ready_r     <= ready_nxt;
      miss_r      <= miss_nxt;
    end
  end

  assign pins_o       = pins_r;
  assign data_o       = data_r;
  assign data_valid_o = valid_r;
  assign data_last_o  = last_r;
  assign ready_o      = ready_r;
  assign busy_miss_o  = miss_r;
endmodule : acs_sequencer
`default_nettype wire

// >>> verif/acs_sequencer_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.svh"
// watches the converter-side pins of the sequencer
module acs_sequencer_chk
  import acs_pkg::*;
#(
  parameter int TW            = 24,
  parameter int WAKE_STANDBY_CONTROL_CYC = 25000
) (
  input wire logic                   sys_clk_i,
  input wire logic                   rst_n_i,
  input wire logic                   ce_i,
  input wire logic                   start_i,
  input wire acs_pkg::acs_cfg_type   cfg_i,
  input wire logic [TW-1:0]          stagger_i,
  input wire logic                   busy_i,
  input wire logic [`ACS_WORD_W-1:0] db_i,
  input wire acs_pkg::acs_pins_type  pins_o,
  input wire logic [`ACS_WORD_W-1:0] data_o,
  input wire logic                   data_valid_o,
  input wire logic                   data_last_o,
  input wire logic                   ready_o,
  input wire logic                   busy_miss_o
);
  logic [2:0]  low_r;
  logic [11:0] gap_r;
  logic [23:0] wake_r;
  logic        slow_r;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // saturating counters, so a long quiet stretch never wraps to zero
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      low_r  <= 3'h7;
      gap_r  <= 12'hFFF;
      wake_r <= 24'hFFFFFF;
      slow_r <= 1'b0;
    end else begin
      // spacing owed is set by the mode of the previous start
      slow_r <= $rose(pins_o.conversion_start_a) ? cfg_i.serial_slow :
                slow_r;
      low_r  <= busy_i ? 3'h0 : (low_r == 3'h7 ? low_r : low_r + 3'h1);
      gap_r  <= $rose(pins_o.conversion_start_a) ? 12'h0 :
                (gap_r == 12'hFFF ? gap_r : gap_r + 12'h1);
      wake_r <= $rose(pins_o.standby_control) ? 24'h0 :
                (&wake_r ? wake_r : wake_r + 24'h1);
    end
  end

  property p_reset_gap;
    $fell(pins_o.reset) |-> !pins_o.conversion_start_a [*7];
  endproperty
  a_reset_gap: assert property (p_reset_gap)
    else $error("start too soon after converter reset");
  property p_start_a_high;
    $rose(pins_o.conversion_start_a) |-> pins_o.conversion_start_a [*7];
  endproperty
  a_start_a_high: assert property (p_start_a_high)
    else $error("start a pulse too short");
  property p_start_b_high;
    $rose(pins_o.conversion_start_b) |-> pins_o.conversion_start_b [*7];
  endproperty
  a_start_b_high: assert property (p_start_b_high)
    else $error("start b pulse too short");
  property p_cs_after_busy;
    $fell(pins_o.cs_n) && !cfg_i.read_during |-> !$past(busy_i) && !busy_i;
  endproperty
  a_cs_after_busy: assert property (p_cs_after_busy)
    else $error("select while converter busy");
  property p_cs_end;
    $fell(busy_i) && cfg_i.read_during |=> pins_o.cs_n && pins_o.rd_n;
  endproperty
  a_cs_end: assert property (p_cs_end)
    else $error("select held past busy fall");
  property p_linked_gap;
    $rose(pins_o.cs_n) && cfg_i.cs_rd_linked |-> pins_o.cs_n [*6];
  endproperty
  a_linked_gap: assert property (p_linked_gap)
    else $error("linked select high too short");
  property p_os_hold;
    $changed(pins_o.oversample_select) |-> low_r >= 3'h5;
  endproperty
  a_os_hold: assert property (p_os_hold)
    else $error("ratio select moved near busy edge");
  property p_spacing;
    $rose(pins_o.conversion_start_a) |->
      gap_r >= (slow_r ? 12'hA40 : 12'h4E1);
  endproperty
  a_spacing: assert property (p_spacing)
    else $error("conversion cycles too close");
  property p_wake;
    $rose(pins_o.conversion_start_a) |-> wake_r >= WAKE_STANDBY_CONTROL_CYC - 1;
  endproperty
  a_wake: assert property (p_wake)
    else $error("start too soon after wake");

  // main scenarios reached
  c_start: cover property (start_i && ready_o);
  c_last: cover property (data_last_o);
  c_miss: cover property (busy_miss_o);
  c_cut: cover property ($fell(busy_i) && !pins_o.cs_n);
endmodule : acs_sequencer_chk

bind acs_sequencer acs_sequencer_chk #(.TW(TW),
  .WAKE_STANDBY_CONTROL_CYC(WAKE_STANDBY_CONTROL_CYC)) i_acs_sequencer_chk (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
  .start_i(start_i), .cfg_i(cfg_i), .stagger_i(stagger_i),
  .busy_i(busy_i), .db_i(db_i), .pins_o(pins_o), .data_o(data_o),
  .data_valid_o(data_valid_o), .data_last_o(data_last_o),
  .ready_o(ready_o), .busy_miss_o(busy_miss_o));
`default_nettype wire

// >>> verif/acs_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
// converter stand-in: busy after a start edge, indexed words on reads
module acs_conv_model (
  input  wire logic                  sys_clk_i,
  input  wire acs_pkg::acs_pins_type pins_i,
  input  wire logic [3:0]            lat_i,
  input  wire logic [9:0]            conv_i,
  input  wire logic                  mute_i,
  output logic                       busy_o,
  output logic [15:0]                db_o
);
  import acs_pkg::*;
  logic        sa_q = 1'b0;
  logic        rd_q = 1'b1;
  logic [10:0] cnt  = 11'h0;
  logic [3:0]  word = 4'h0;

  // busy follows the start edge after lat_i cycles, kept under 10
  assign busy_o = (cnt != 11'h0) && (cnt <= {1'b0, conv_i});

  // bus shows a word only while selected and strobed, else garbage
  always @(posedge sys_clk_i) begin
    sa_q <= pins_i.conversion_start_a;
    rd_q <= pins_i.rd_n;
    if (pins_i.reset) begin
      cnt  <= 11'h0;
      word <= 4'h0;
    end else if (pins_i.conversion_start_a && !sa_q) begin
      cnt  <= mute_i ? 11'h0 : {7'h0, lat_i} + {1'b0, conv_i};
      word <= 4'h0;
    end else begin
      if (cnt != 11'h0) cnt <= cnt - 11'h1;
      if (pins_i.rd_n && !rd_q) word <= word + 4'h1;
    end
    if (!pins_i.cs_n && !pins_i.rd_n) db_o <= {12'hA5C, word};
    else db_o <= ~db_o;
  end
endmodule : acs_conv_model
`default_nettype wire

// >>> verif/test_acs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_acs_sequencer;
  import acs_pkg::*;
  logic         sys_clk_i = 1'b0;
  logic         rst_n_i   = 1'b0;
  logic         ce_i      = 1'b1;
  logic         start_i   = 1'b0;
  acs_cfg_type  cfg_i     = '0;
  logic [23:0]  stagger_i = 24'h0;
  logic [3:0]   lat       = 4'h3;
  logic [9:0]   conv      = 10'h064;
  logic         mute      = 1'b0;
  logic         busy, valid, last, ready, miss;
  logic [15:0]  db, data;
  acs_pins_type pins;
  logic         pa = 1'b0;
  logic         pb = 1'b0;
  int           err_total = 0;
  int           num_checks = 0;
  int           cyc = 0, ra = 0, rb = 0, n_last = 0, n_miss = 0;
  logic [15:0]  words [$];

  acs_sequencer #(.WAKE_STANDBY_CONTROL_CYC(20), .WAKE_INT_CYC(40),
    .WAKE_EXT_CYC(30), .SKEW_MAX_CYC(50)) i_acs_sequencer (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .start_i(start_i), .cfg_i(cfg_i), .stagger_i(stagger_i),
    .busy_i(busy), .db_i(db), .pins_o(pins), .data_o(data),
    .data_valid_o(valid), .data_last_o(last), .ready_o(ready),
    .busy_miss_o(miss));
  acs_conv_model i_acs_conv_model (.sys_clk_i(sys_clk_i), .pins_i(pins),
    .lat_i(lat), .conv_i(conv), .mute_i(mute), .busy_o(busy), .db_o(db));

  // 250 MHz
  always #2 sys_clk_i = ~sys_clk_i;

  // edge times and read words as seen at the pins
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    pa <= pins.conversion_start_a;
    pb <= pins.conversion_start_b;
    if (pins.conversion_start_a && !pa) ra <= cyc;
    if (pins.conversion_start_b && !pb) rb <= cyc;
    if (valid === 1'b1) words.push_back(data);
    if (last === 1'b1) n_last <= n_last + 1;
    if (miss === 1'b1) n_miss <= n_miss + 1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : tick

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  // bounded wait, a stuck sequencer shows as a mismatch
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 8000) begin
      tick(1);
      n++;
    end
    chk("ready wait", n < 8000, 1'b1);
  endtask : wait_ready

  task automatic go();
    wait_ready();
    words.delete();
    n_last = 0;
    start_i = 1'b1;
    tick(1);
    start_i = 1'b0;
  endtask : go

  task automatic t_reset();
    int n;
    n = 0;
    // a low enable must stretch the converter reset pulse
    ce_i = 1'b0;
    tick(5);
    ce_i = 1'b1;
    chk("reset pin", pins.reset, 1'b1);
    while (ready !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    chk("reset to ready", n >= 20, 1'b1);
    chk("reset pin off", pins.reset, 1'b0);
    $display("test reset finished");
  endtask : t_reset

  task automatic t_read(input logic linked);
    cfg_i.cs_rd_linked = linked;
    go();
    wait_ready();
    chk("ratio pins", pins.oversample_select, 3'h5);
    chk("range pin", pins.range_hi, 1'b1);
    chk("word count", words.size(), 16);
    chk("last count", n_last, 1);
    for (int i = 0; i < words.size(); i++) begin
      chk("word", words[i], {12'hA5C, i[3:0]});
    end
    $display("test read finished");
  endtask : t_read

  task automatic t_space(input logic slow);
    int first, lim, n;
    lim = slow ? 2625 : 1250;
    cfg_i.serial_slow = slow;
    wait_ready();
    start_i = 1'b1;
    tick(2);
    first = ra;
    tick(lim + 20);
    start_i = 1'b0;
    n = ra - first;
    chk("cycle gap", n >= lim && n <= lim + 20, 1'b1);
    wait_ready();
    cfg_i.serial_slow = 1'b0;
    $display("test spacing finished");
  endtask : t_space

  task automatic t_stagger();
    lat = 4'h9;
    for (int k = 0; k < 2; k++) begin
      stagger_i = k ? 24'h00003C : 24'h000005;
      go();
      wait_ready();
      chk("stagger", rb - ra, k ? 50 : 5);
    end
    stagger_i = 24'h0;
    lat = 4'h3;
    $display("test stagger finished");
  endtask : t_stagger

  task automatic t_during();
    cfg_i.read_during = 1'b1;
    conv = 10'h028;
    go();
    wait_ready();
    chk("cut burst", words.size() > 0 && words.size() < 16, 1'b1);
    chk("cut last", n_last, 0);
    chk("first word", words[0], 16'hA5C0);
    cfg_i.read_during = 1'b0;
    conv = 10'h064;
    $display("test during finished");
  endtask : t_during

  task automatic t_miss();
    mute = 1'b1;
    n_miss = 0;
    go();
    wait_ready();
    chk("busy miss", n_miss, 1);
    mute = 1'b0;
    $display("test miss finished");
  endtask : t_miss

  task automatic t_power(input acs_power_type pw, input logic ext,
                         input int lim);
    int t0, n;
    wait_ready();
    cfg_i.power = pw;
    cfg_i.ext_ref = ext;
    tick(3);
    chk("sleep pin", pins.standby_control, 1'b0);
    chk("sleep kind", pins.range_hi, pw == ACS_PWR_STANDBY);
    cfg_i.power = ACS_PWR_NORMAL;
    n = 0;
    while (pins.standby_control !== 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    t0 = cyc;
    go();
    tick(2);
    chk("wake wait", ra - t0 >= lim, 1'b1);
    wait_ready();
    $display("test power finished");
  endtask : t_power

  // main sequence
  initial begin
    cfg_i.os_ratio = 3'h5;
    cfg_i.range_hi = 1'b1;
    tick(10);
    rst_n_i = 1'b1;
    t_reset();
    t_read(1'b0);
    t_read(1'b1);
    t_space(1'b0);
    t_space(1'b1);
    t_stagger();
    t_during();
    t_miss();
    t_power(ACS_PWR_STANDBY, 1'b0, 20);
    t_power(ACS_PWR_SHUTDOWN, 1'b1, 30);
    t_power(ACS_PWR_SHUTDOWN, 1'b0, 40);
    stop_test();
  end

  // watchdog, about twice the expected run
  initial begin
    repeat (40000) @(posedge sys_clk_i);
    err_total++;
    $display("timeout waiting for the sequencer");
    stop_test();
  end
endmodule : test_acs_sequencer
`default_nettype wire
